// ===== serial_rx_defs.svh
// Constants for the asynchronous serial receiver
// Assumes inclusion by bare name from the design file
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define RX_DATA_OFFSET 8'h24
`define RX_STATUS_OFFSET 8'h35
// -----------------------------------------------------------------
// Status bit positions
// -----------------------------------------------------------------
`define ST_NINTH_BIT 2
`define ST_OVERRUN_BIT 4
`define ST_FULL_BIT 5
`define ST_FRAMING_BIT 6
`define ST_NOISE_BIT 7
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define OVERSAMPLE_LAST 4'hf
`define VOTE_S1 4'h7
`define VOTE_S2 4'h8
`define VOTE_S3 4'h9
`define START_HIGHS 2'h3
`define BREAK_BITS 4'ha
// Index of the last stop bit, start bit counted as index 0
`define FRAME_BITS_SHORT 4'h9
`define FRAME_BITS_LONG 4'ha
`define RESET_BYTE 8'h00
`endif

// ===== serial_rx_pkg.sv
// Types for the asynchronous serial receiver
// Assumes the defs header sits in the same folder
package serial_rx_pkg;
  typedef enum logic [1:0] {
    fmt_8n1,
    fmt_8n2,
    fmt_8p1,
    fmt_9n1
  } frame_format_type;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic noise;
    logic framing;
  } rx_word_type;
endpackage : serial_rx_pkg

// ===== async_serial_receiver.sv
// Receive half of an asynchronous NRZ serial port with holding buffer
// Assumes os_tick is a one-cycle core_clk pulse at 16x the bit rate
`timescale 1ns/100ps
`include "serial_rx_defs.svh"

// Contract
// - Frame is start, 8 or 9 data, stop
// - Sample line at sixteen times bit rate
// - Start is low after three highs
// - Start launches acquisition per selected format
// - Four selectable frame formats
// - Parity selectable even or odd
// - Ninth bit in status bit 2
// - Stop loads buffer, sets full flag
// - Data read at 24h clears full
// - Load while full sets overrun flag
// - Overrun keeps old buffered word
// - Three-sample majority, disagreement sets noise
// - Parity or stop failure sets framing
// - Ten low bits signal line break
module async_serial_receiver (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Serial line and baud tick
  input wire logic rx_pin,
  input wire logic os_tick,
  // Configuration
  input wire serial_rx_pkg::frame_format_type frame_format,
  input wire logic parity_odd,
  // Register read port
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  output logic [7:0] reg_rdata,
  // Events
  output logic line_break_irq
);
  typedef enum logic [1:0] {st_idle, st_bits, st_done} rx_state_type;

  // -----------------------------------------------------------------
  // Line synchroniser
  // -----------------------------------------------------------------
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // -----------------------------------------------------------------
  // Recovery state
  // -----------------------------------------------------------------
  rx_state_type state;
  logic [3:0] phase;
  logic [3:0] bit_idx;
  logic [1:0] high_count;
  logic [2:0] votes;
  logic [10:0] shift;
  logic [3:0] low_run;
  logic word_ready;
  serial_rx_pkg::rx_word_type new_word;

  wire vote_now = os_tick && (phase == `VOTE_S3);
  wire [2:0] vote_set = {votes[1:0], rx_sync};
  wire bit_val = (vote_set[0] & vote_set[1]) | (vote_set[0] & vote_set[2]) | (vote_set[1] & vote_set[2]);
  wire bit_noisy = !(vote_set == 3'h7 || vote_set == 3'h0);
  // bit count per format, stop included
  wire [3:0] frame_bits = (frame_format == serial_rx_pkg::fmt_8n1) ? `FRAME_BITS_SHORT : `FRAME_BITS_LONG;
  wire last_bit = (bit_idx == frame_bits);
  wire bit_end = os_tick && (phase == `OVERSAMPLE_LAST);
  wire [10:0] next_shift = {bit_val, shift[10:1]};
  logic noise_acc;
  wire next_noise = noise_acc | bit_noisy;

  wire [7:0] f_data = (frame_format == serial_rx_pkg::fmt_8n1) ? next_shift[9:2] : next_shift[8:1];
  wire f_ninth = next_shift[9] && (frame_format == serial_rx_pkg::fmt_9n1);
  // parity across data and parity bit
  wire par_bad = (^next_shift[9:1]) != parity_odd;
  wire stop_bad = (frame_format == serial_rx_pkg::fmt_8n2) ? !(next_shift[10] && next_shift[9]) : !next_shift[10];
  wire frame_bad = stop_bad || ((frame_format == serial_rx_pkg::fmt_8p1) && par_bad);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= st_idle;
      phase <= 4'h0;
      bit_idx <= 4'h0;
      high_count <= 2'h0;
      votes <= 3'h0;
      shift <= 11'h000;
      noise_acc <= 1'b0;
      word_ready <= 1'b0;
      new_word <= '0;
    end else begin
      word_ready <= 1'b0;
      case (state)
        st_idle: begin
          if (os_tick) begin
            if (rx_sync) begin
              high_count <= (high_count == `START_HIGHS) ? high_count : high_count + 2'h1;
            end else if (high_count == `START_HIGHS) begin
              state <= st_bits;
              phase <= 4'h1;
              bit_idx <= 4'h0;
              high_count <= 2'h0;
              noise_acc <= 1'b0;
            end else begin
              high_count <= 2'h0;
            end
          end
        end
        st_bits: begin
          if (os_tick) begin
            phase <= phase + 4'h1;
          end
          if (os_tick && (phase == `VOTE_S1 || phase == `VOTE_S2)) begin
            votes <= {votes[1:0], rx_sync};
          end
          if (vote_now) begin
            shift <= next_shift;
            noise_acc <= next_noise;
            if (last_bit) begin
              state <= st_done;
              word_ready <= 1'b1;
              new_word <= '{data: f_data, ninth: f_ninth, noise: next_noise, framing: frame_bad};
            end
          end
          if (bit_end) begin
            bit_idx <= bit_idx + 4'h1;
          end
        end
        st_done: begin
          // Wait out the stop bit before hunting a new start
          if (bit_end) begin
            state <= st_idle;
            // only a high stop counts as highs
            high_count <= shift[10] ? `START_HIGHS : 2'h0;
          end else if (os_tick) begin
            phase <= phase + 4'h1;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Line break detector
  // -----------------------------------------------------------------
  wire bit_sample = (state == st_bits) && vote_now;
  // A high line while idle ends any run of low bits
  wire idle_high = (state == st_idle) && os_tick && rx_sync;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_run <= 4'h0;
      line_break_irq <= 1'b0;
    end else begin
      line_break_irq <= bit_sample && !bit_val && (low_run == `BREAK_BITS - 4'h1);
      if (bit_sample) begin
        low_run <= bit_val ? 4'h0 : ((low_run == `BREAK_BITS) ? low_run : low_run + 4'h1);
      end else if (idle_high) begin
        low_run <= 4'h0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Holding buffer and status
  // -----------------------------------------------------------------
  serial_rx_pkg::rx_word_type held;
  logic full;
  logic overrun;
  wire read_data = reg_rd && (reg_addr == `RX_DATA_OFFSET);
  wire load_ok = word_ready && !full;
  logic [7:0] status;
  always_comb begin
    status = `RESET_BYTE;
    status[`ST_NOISE_BIT] = held.noise;
    status[`ST_FRAMING_BIT] = held.framing;
    status[`ST_FULL_BIT] = full;
    status[`ST_OVERRUN_BIT] = overrun;
    // ninth bit only in 9-bit format
    status[`ST_NINTH_BIT] = held.ninth && (frame_format == serial_rx_pkg::fmt_9n1);
  end
  wire [7:0] next_rdata = !reg_rd ? reg_rdata :
                          (reg_addr == `RX_DATA_OFFSET) ? held.data :
                          (reg_addr == `RX_STATUS_OFFSET) ? status : `RESET_BYTE;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      held <= '0;
      full <= 1'b0;
      overrun <= 1'b0;
      reg_rdata <= `RESET_BYTE;
    end else begin
      reg_rdata <= next_rdata;
      if (load_ok) begin
        held <= new_word;
      end
      // full set wins over read clear
      if (load_ok) begin
        full <= 1'b1;
      end else if (read_data) begin
        full <= 1'b0;
      end
      if (word_ready && full) begin
        overrun <= 1'b1;
      end else if (load_ok) begin
        overrun <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  sequence start_taken;
    state == st_idle ##1 state == st_bits;
  endsequence

  a_full_on_load: assert property (@(posedge core_clk) disable iff (srst)
    word_ready && !full |=> full) else $error("full not set after load");
  a_read_clears: assert property (@(posedge core_clk) disable iff (srst)
    read_data && !load_ok |=> !full) else $error("read did not clear full");
  a_overrun_set: assert property (@(posedge core_clk) disable iff (srst)
    word_ready && full |=> overrun) else $error("overrun not flagged");
  a_overrun_keep: assert property (@(posedge core_clk) disable iff (srst)
    word_ready && full |=> held == $past(held)) else $error("held word altered on overrun");
  a_start_needs_highs: assert property (@(posedge core_clk) disable iff (srst)
    start_taken |-> $past(high_count) == `START_HIGHS) else $error("start without highs");
  a_noise_vote: assert property (@(posedge core_clk) disable iff (srst)
    bit_sample && bit_noisy && !last_bit |=> noise_acc) else $error("noise not accumulated");
  a_break_pulse: assert property (@(posedge core_clk) disable iff (srst)
    line_break_irq |-> $past(low_run) == `BREAK_BITS - 4'h1) else $error("break at wrong count");
  a_ninth_status: assert property (@(posedge core_clk) disable iff (srst)
    frame_format != serial_rx_pkg::fmt_9n1 |-> !status[`ST_NINTH_BIT]) else $error("ninth bit outside 9-bit mode");
endmodule : async_serial_receiver

// ===== serial_tx_model.sv
// Far-end transmitter model driving the receiver's serial line
// Assumes os_tick pulses once per sixteenth of a bit in the core_clk domain
`timescale 1ns/100ps
module serial_tx_model (
  // Timing
  input wire logic core_clk,
  input wire logic os_tick,
  // Serial line
  output logic line
);
  initial line = 1'b1;

  // Holds a level for n ticks, inverting only the middle vote when asked
  task automatic hold(input logic v, input int n, input logic glitch);
    for (int j = 0; j < n; j++) begin
      line <= (glitch && j == 8) ? ~v : v;
      @(posedge core_clk iff os_tick);
    end
  endtask : hold

  task automatic send(input logic [8:0] w, input logic [1:0] fmt, input logic odd, input logic err,
                      input int nz, input int gap);
    logic [9:0] bits;
    int nb;
    nb = (fmt == 2'd0) ? 9 : 10;
    bits = {1'b1, (fmt == 2'd2) ? (^w[7:0] ^ odd) : ((fmt == 2'd3) ? w[8] : 1'b1), w[7:0]};
    bits[(fmt == 2'd3) ? 9 : 8] ^= err;
    @(posedge core_clk iff os_tick);
    hold(1'b1, gap, 1'b0);
    hold(1'b0, 16, 1'b0);
    for (int i = 0; i < nb; i++) begin
      hold(bits[i], 16, nz == i + 1);
    end
    line <= 1'b1;
  endtask : send
endmodule : serial_tx_model

// ===== async_serial_receiver_bench.sv
// Self-checking bench for the serial receiver against an integer model
// Assumes the design files and the transmitter model are compiled first
`timescale 1ns/100ps
module async_serial_receiver_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic os_tick = 1'b0;
  logic rx_pin;
  serial_rx_pkg::frame_format_type frame_format = serial_rx_pkg::fmt_8n1;
  logic parity_odd = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_rdata;
  logic line_break_irq;
  logic [1:0] div = 2'h0;
  int err_total = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  int m_data = 0;
  int m_nz = 0;
  int m_fr = 0;
  int m_full = 0;
  int m_ovr = 0;
  int m_nin = 0;
  int last_err = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    div <= div + 2'h1;
    os_tick <= (div == 2'h3);
  end
  always @(posedge core_clk) begin
    if (line_break_irq === 1'b1) irq_cnt++;
  end

  async_serial_receiver DUT (.core_clk(core_clk), .srst(srst), .rx_pin(rx_pin), .os_tick(os_tick),
    .frame_format(frame_format), .parity_odd(parity_odd), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .line_break_irq(line_break_irq));
  serial_tx_model tx (.core_clk(core_clk), .os_tick(os_tick), .line(rx_pin));

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  function automatic logic [7:0] stat_exp();
    return {m_nz[0], m_fr[0], m_full[0], m_ovr[0], 1'b0, (m_nin[0] & (frame_format == serial_rx_pkg::fmt_9n1)), 2'b00};
  endfunction : stat_exp

  task automatic frame(input logic [8:0] w, input int fmt, input logic err, input int nz, input logic take);
    logic [7:0] d;
    logic odd;
    @(posedge core_clk);
    odd = 1'($urandom);
    frame_format <= serial_rx_pkg::frame_format_type'(fmt[1:0]);
    parity_odd <= odd;
    // A low stop leaves no preset highs, so the next start waits longer
    tx.send(w, fmt[1:0], odd, err, nz, (last_err != 0) ? 4 : $urandom_range(2, 0));
    last_err = err;
    if (m_full != 0) begin
      m_ovr = 1;
    end else begin
      m_data = w[7:0];
      m_nin = (fmt == 3) ? w[8] : 0;
      m_nz = (nz > 0);
      m_fr = err;
      m_full = 1;
      m_ovr = 0;
    end
    rd(8'h35, d);
    check(d, stat_exp());
    if (take) begin
      rd(8'h24, d);
      check(d, m_data[7:0]);
      m_full = 0;
      rd(8'h35, d);
      check(d, stat_exp());
    end
    $display("frame w=%h fmt=%0d done", w, fmt);
  endtask : frame

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'hedfe8ab3));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h35, d);
    check(d, 8'h00);
    rd(8'h24, d);
    check(d, 8'h00);
    rd(8'h7f, d);
    check(d, 8'h00);
    $display("reset test done");
    // Bit 0 forced high keeps random frames short of a break
    for (int i = 0; i < 20; i++) begin
      frame(9'($urandom) | 9'h001, i % 4, $urandom_range(3, 0) == 0,
            ($urandom_range(2, 0) == 0) ? $urandom_range(9, 1) : 0, $urandom_range(2, 0) != 0);
    end
    check(irq_cnt[7:0], 8'h00);
    frame(9'h000, 0, 1'b1, 0, 1'b1);
    check(irq_cnt[7:0], 8'h01);
    $display("break test done");
    print_verdict();
  end
endmodule : async_serial_receiver_bench
